// file: design/ext_irq_pkg.sv
// constants for the external interrupt pair block
// ==========================================================
package ext_irq_pkg;
  localparam logic [7:0] CFG_ADDR = 8'he4;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam int B_POL = 7;
  localparam int B_SEL_HI = 6;
  localparam int B_SEL_LO = 4;
  localparam int A_POL = 3;
  localparam int A_SEL_HI = 2;
  localparam int A_SEL_LO = 0;
  localparam int NUM_IRQ = 2;
  localparam int PORT_W = 8;
endpackage : ext_irq_pkg

// file: design/external_interrupt_pair.sv
// external interrupt pair: config register, pin select, synchronise, pending flags
`timescale 1ns/10ps
module external_interrupt_pair (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // trigger type bits held in the timer control register
  input wire logic irq_a_trigger_type,
  input wire logic irq_b_trigger_type,
  // cpu vectoring acknowledges, one-cycle pulses
  input wire logic irq_a_ack,
  input wire logic irq_b_ack,
  // port 0 pins
  input wire logic [ext_irq_pkg::PORT_W-1:0] port0_pins,
  // pending flags
  output logic irq_a_pending,
  output logic irq_b_pending
);
  import ext_irq_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [PORT_W-1:0] sync1;
    logic [PORT_W-1:0] sync2;
    logic [NUM_IRQ-1:0] act_d;
    logic [NUM_IRQ-1:0] pend;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [NUM_IRQ-1:0] act;
  logic [NUM_IRQ-1:0] rise;
  logic [NUM_IRQ-1:0] trig;
  logic [NUM_IRQ-1:0] ack;

  assign trig = {irq_b_trigger_type, irq_a_trigger_type};
  assign ack = {irq_b_ack, irq_a_ack};

  // ==========================================================
  // pin selection and polarity, one copy per input
  // only reads the synchronised copy, so routed peripherals are untouched
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_sel
    localparam int SEL_LO = (g == 0) ? A_SEL_LO : B_SEL_LO;
    localparam int SEL_HI = (g == 0) ? A_SEL_HI : B_SEL_HI;
    localparam int POL = (g == 0) ? A_POL : B_POL;
    logic [SEL_HI-SEL_LO:0] sel;
    assign sel = st_r.cfg[SEL_HI:SEL_LO];
    assign act[g] = st_r.sync2[sel] == st_r.cfg[POL];
    // transition into the active level, whichever polarity is chosen
    assign rise[g] = act[g] && !st_r.act_d[g];
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = port0_pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.act_d = act;
    if (reg_wr && reg_addr == CFG_ADDR) begin
      st_nxt.cfg = reg_wdata;
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (trig[i]) begin
        // new edge beats a simultaneous acknowledge
        if (rise[i]) begin
          st_nxt.pend[i] = 1'b1;
        end else if (ack[i]) begin
          st_nxt.pend[i] = 1'b0;
        end
      end else begin
        st_nxt.pend[i] = act[i];
      end
    end
    st_nxt.rdata = (reg_addr == CFG_ADDR) ? st_nxt.cfg : 8'h00;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // syncs start at the idle level of the default active-low inputs,
      // so neither a false edge nor a level pulse follows reset
      st_r <= '{cfg: CFG_RESET, sync1: '1, sync2: '1, act_d: '0, pend: '0, rdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq_a_pending = st_r.pend[0];
  assign irq_b_pending = st_r.pend[1];

  // ==========================================================
  // checks
  AST_EDGE_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && act[0] && !st_r.act_d[0]) |=> irq_a_pending)
    else $error("edge did not set pending a");
  AST_ACK_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && ack[0] && !(act[0] && !st_r.act_d[0])) |=> !irq_a_pending)
    else $error("ack did not clear pending a");
  AST_LEVEL_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[1] && !$past(trig[1])) |-> irq_b_pending == $past(act[1]))
    else $error("level pending b does not follow input");
  AST_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(rst_n) && $past(rst_n, 2)) |-> st_r.sync2 == $past(port0_pins, 2))
    else $error("synchroniser depth wrong");
  AST_POL_A: assert property (@(posedge mclk) disable iff (!rst_n)
    act[0] == (st_r.cfg[A_POL] ? st_r.sync2[st_r.cfg[A_SEL_HI:A_SEL_LO]] : !st_r.sync2[st_r.cfg[A_SEL_HI:A_SEL_LO]]))
    else $error("polarity a wrong");
  AST_SEL_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[B_POL] && st_r.sync2 == (8'h01 << st_r.cfg[B_SEL_HI:B_SEL_LO])) |-> act[1])
    else $error("pin select b wrong");
  AST_CFG_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == CFG_ADDR) |=> reg_rdata == $past(reg_wdata))
    else $error("config write not read back");
  AST_EDGE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && irq_a_pending && !ack[0]) |=> irq_a_pending)
    else $error("edge pending a lost without ack");

  // ==========================================================
  // edge mode, both inputs
  AST_EDGE_SET_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && rise[1]) |=> irq_b_pending)
    else $error("edge did not set pending b");
  AST_ACK_CLR_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && ack[1] && !rise[1]) |=> !irq_b_pending)
    else $error("ack did not clear pending b");
  AST_EDGE_HOLD_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && irq_b_pending && !ack[1]) |=> irq_b_pending)
    else $error("edge pending b lost without ack");
  // a new edge must not be swallowed by the ack of the previous one
  AST_ACK_RACE_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && rise[0] && ack[0]) |=> irq_a_pending)
    else $error("edge lost to ack on a");
  AST_ACK_RACE_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && rise[1] && ack[1]) |=> irq_b_pending)
    else $error("edge lost to ack on b");
  AST_NO_SPUR_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && !irq_a_pending && !rise[0]) |=> !irq_a_pending)
    else $error("pending a set without edge");
  AST_NO_SPUR_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && !irq_b_pending && !rise[1]) |=> !irq_b_pending)
    else $error("pending b set without edge");
  AST_EDGE_INACT_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[0] && !act[0] && !irq_a_pending) |=> !irq_a_pending)
    else $error("pending a set by inactive input");
  AST_EDGE_INACT_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig[1] && !act[1] && !irq_b_pending) |=> !irq_b_pending)
    else $error("pending b set by inactive input");

  // ==========================================================
  // level mode, both inputs
  // the ack is ignored here: the source itself must drop the level
  AST_LEVEL_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[0] && !$past(trig[0])) |-> irq_a_pending == $past(act[0]))
    else $error("level pending a does not follow input");
  AST_LEVEL_ACK_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[0] && ack[0] && act[0]) |=> irq_a_pending)
    else $error("ack cleared level pending a");
  AST_LEVEL_ACK_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[1] && ack[1] && act[1]) |=> irq_b_pending)
    else $error("ack cleared level pending b");
  AST_LEVEL_DROP_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[0] && !act[0]) |=> !irq_a_pending)
    else $error("level pending a stays with inactive input");
  AST_LEVEL_DROP_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[1] && !act[1]) |=> !irq_b_pending)
    else $error("level pending b stays with inactive input");
  AST_LEVEL_RISE_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[0] && act[0]) |=> irq_a_pending)
    else $error("level pending a missing with active input");
  AST_LEVEL_RISE_B: assert property (@(posedge mclk) disable iff (!rst_n)
    (!trig[1] && act[1]) |=> irq_b_pending)
    else $error("level pending b missing with active input");

  // ==========================================================
  // polarity, judged with all pins at one level
  AST_POL_B_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    (!st_r.cfg[B_POL] && st_r.sync2 == 8'h00) |-> act[1])
    else $error("active low b not active on low pin");
  AST_POL_B_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[B_POL] && st_r.sync2 == 8'h00) |-> !act[1])
    else $error("active high b active on low pin");
  AST_POL_A_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[A_POL] && st_r.sync2 == 8'hff) |-> act[0])
    else $error("active high a not active on high pin");
  AST_POL_A_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    (!st_r.cfg[A_POL] && st_r.sync2 == 8'hff) |-> !act[0])
    else $error("active low a active on high pin");

  // ==========================================================
  // pin select, one pin apart from the others
  AST_SEL_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[A_POL] && st_r.sync2 == (8'h01 << st_r.cfg[A_SEL_HI:A_SEL_LO])) |-> act[0])
    else $error("pin select a wrong");
  AST_SEL_A_OTHER: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[A_POL] && st_r.sync2 == ~(8'h01 << st_r.cfg[A_SEL_HI:A_SEL_LO])) |-> !act[0])
    else $error("pin select a reads another pin");
  AST_SEL_B_OTHER: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.cfg[B_POL] && st_r.sync2 == ~(8'h01 << st_r.cfg[B_SEL_HI:B_SEL_LO])) |-> !act[1])
    else $error("pin select b reads another pin");

  // ==========================================================
  // synchroniser and edge memory
  AST_SYNC1: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> st_r.sync1 == $past(port0_pins))
    else $error("first synchroniser stage wrong");
  AST_ACT_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> st_r.act_d == $past(act))
    else $error("edge memory does not follow active state");

  // ==========================================================
  // register port
  AST_CFG_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr && reg_addr == CFG_ADDR) |=> st_r.cfg == $past(st_r.cfg))
    else $error("config changed without write");
  AST_RDATA_CFG: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_addr == CFG_ADDR && !reg_wr) |=> reg_rdata == $past(st_r.cfg))
    else $error("config read wrong");
  AST_RDATA_OTHER: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_addr != CFG_ADDR) |=> reg_rdata == 8'h00)
    else $error("unmapped address reads non-zero");
endmodule : external_interrupt_pair

// file: bench/irq_source.sv
// external interrupt sources on port 0
`timescale 1ns/10ps
module irq_source (
  // clock
  input wire logic mclk,
  // pins
  output logic [7:0] port0_pins
);
  // crossbar skips these pins, so only these sources drive them
  initial port0_pins = 8'h7f;
  // drives one pin to a level at the next clock edge; the level holds until that pin is driven again
  task automatic drive(input int p, input logic v);
    @(posedge mclk);
    port0_pins[p] <= v;
  endtask : drive
endmodule : irq_source

// file: bench/testbench.sv
// self-checking bench for the external interrupt pair
`timescale 1ns/10ps
module testbench;
  import ext_irq_pkg::*;
  logic mclk = 0, rst_n = 0, reg_wr = 0, irq_a_ack = 0, irq_b_ack = 0;
  logic irq_a_trigger_type = 1, irq_b_trigger_type = 0, irq_a_pending, irq_b_pending;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port0_pins;
  int errors = 0, checks_done = 0;
  irq_source src_u (.mclk, .port0_pins);
  external_interrupt_pair dut_u (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .irq_a_trigger_type,
    .irq_b_trigger_type, .irq_a_ack, .irq_b_ack, .port0_pins, .irq_a_pending, .irq_b_pending);
  initial forever #12.5 mclk = ~mclk;
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) reg_addr <= a;
    @(posedge mclk) #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic ack(input logic b);
    @(posedge mclk) {irq_b_ack, irq_a_ack} <= b ? 2'b10 : 2'b01;
    @(posedge mclk) {irq_b_ack, irq_a_ack} <= 2'b00;
    #1;
  endtask : ack
  task automatic wt(input logic b, input logic v);
    for (int i = 0; i < 8 && (b ? irq_b_pending : irq_a_pending) !== v; i++) @(posedge mclk) #1;
    chk("pending", {7'h0, v}, {7'h0, b ? irq_b_pending : irq_a_pending});
    if ((b ? irq_b_pending : irq_a_pending) !== v) give_verdict();
  endtask : wt
  task automatic t_edge;
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, CFG_ADDR, 8'h0f};
    @(posedge mclk) reg_wr <= 0;
    rd(CFG_ADDR, 8'h0f);
    ack(0);
    chk("pending a", 8'h00, {7'h0, irq_a_pending});
    src_u.drive(7, 1);
    wt(0, 1);
    ack(0);
    chk("pending a", 8'h00, {7'h0, irq_a_pending});
    repeat (4) @(posedge mclk);
    chk("pending a", 8'h00, {7'h0, irq_a_pending});
    src_u.drive(7, 0);
    $display("edge test done");
  endtask : t_edge
  task automatic t_level;
    src_u.drive(0, 0);
    wt(1, 1);
    ack(1);
    chk("pending b", 8'h01, {7'h0, irq_b_pending});
    src_u.drive(0, 1);
    wt(1, 0);
    $display("level test done");
  endtask : t_level
  task automatic t_swap;
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, CFG_ADDR, 8'hf5};
    {irq_b_trigger_type, irq_a_trigger_type} <= 2'b10;
    @(posedge mclk) reg_wr <= 0;
    rd(CFG_ADDR, 8'hf5);
    repeat (3) @(posedge mclk);
    chk("pending a", 8'h00, {7'h0, irq_a_pending});
    chk("pending b", 8'h00, {7'h0, irq_b_pending});
    src_u.drive(7, 1);
    wt(1, 1);
    ack(1);
    chk("pending b", 8'h00, {7'h0, irq_b_pending});
    repeat (4) @(posedge mclk);
    chk("pending b", 8'h00, {7'h0, irq_b_pending});
    src_u.drive(5, 0);
    wt(0, 1);
    ack(0);
    chk("pending a", 8'h01, {7'h0, irq_a_pending});
    src_u.drive(5, 1);
    wt(0, 0);
    $display("swapped mode test done");
  endtask : t_swap
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    rd(CFG_ADDR, CFG_RESET);
    rd(8'h00, 8'h00);
    repeat (4) @(posedge mclk);
    t_edge();
    t_level();
    t_swap();
    give_verdict();
  end
endmodule : testbench
